// ===== rtl/console_status_sense.sv
`timescale 1ns/10ps
// Notes on behaviour
// - status modifier and control-unit end never set
// - sio after ce accepted, de pending: busy+de, clear
// - sio with attention pending: busy plus attention
// - sio with ready device end pending: busy+de
// - between ce accepted and de: busy alone
// - zero count sets ce; writes one share later
// - ce on noop/alarm, end or cancel keys
// - sense ends with ce after one byte
// - lone ce cleared, stored by interrupt or tio
// - de on carrier return, write end, noop, sense
// - ready key sets de only if ready results
// - sio clears a pending de, with or without ce stored
// - tio clears device end; hio keeps it
// - even keyboard parity: uc, equip check, continue
// - write data parity error raises a check
// - not ready: uc plus intervention required
// - undefined command: uc plus command reject
// - printer silent two seconds: equip check, terminate
// - print-sync check: uc plus equip check
// - cancel on read: unit exception, ce, length
// - any sense bit set raises unit check
// - sense bits 4 to 7 never set
// - attention on request key, deferred while busy
module console_status_sense
  import console_pkg::*;
#(
  parameter int TIMEOUT_CYC = PRINT_TIMEOUT_CYC  // printer watchdog length
) (
  // clock and reset
  input  wire logic               CLOCK,
  input  wire logic               RESET,
  // channel side, same clock
  input  wire logic               SIO,           // start i/o with command
  input  wire logic               TIO,           // test i/o
  input  wire logic               HIO,           // halt i/o
  input  wire logic               INT_ACK,       // i/o interruption taken
  input  wire logic [7:0]         CMD_BYTE,      // command at initial selection
  input  wire logic               SHARE,         // share cycle pulse
  input  wire logic               COUNT_ZERO,    // data count is zero
  input  wire logic               LENGTH_SUPPRESS_FLAG,           // length suppress flag
  input  wire logic               DATA_PAR_ERR,  // write data parity error
  input  wire logic               SENSE_SENT,    // sense byte sent this cycle
  // typewriter pins
  input  wire console_pkg::keys_t KEYS,
  // answers
  output console_pkg::csw_t       CHANNEL_STATUS_WORD,
  output logic [7:0]              UNIT_STATUS,
  output logic [7:0]              SENSE_BYTE,
  output logic                    UNIT_READY,
  output logic                    XFER_STOP
);

  import console_pkg::*;

  localparam int TW = $clog2(TIMEOUT_CYC + 1);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation and edges
  keys_t keys_s;                  // synchronised pins
  keys_t keys_d;                  // one cycle older
  keys_t rise;                    // rising edges
  logic  kb_even;                 // keyboard character has even parity

  pin_sync #(.W($bits(keys_t))) u_sync (
    .clk (CLOCK),
    .rst (RESET),
    .d   (KEYS),
    .q   (keys_s)
  );

  // edge history
  always_ff @(posedge CLOCK) begin
    if (RESET) keys_d <= '0;
    else       keys_d <= keys_s;
  end

  assign rise    = keys_s & ~keys_d;
  assign kb_even = ~(^keys_s.kb_char);

  ////////////////////////////////////////////////////////////////////////////
  // state
  op_t           op_r, op_nxt;     // operation in progress
  logic [7:0]    status_r;         // unit status byte
  logic [7:0]    sense_r;          // error sense byte
  logic          ce_acc_r;         // channel end stored, device end owed
  logic          zero_seen_r;      // write hit zero, ce on next share
  logic          il_r;             // incorrect length for next store
  logic          attn_pend_r;      // deferred attention
  logic          ready_r;          // unit ready
  logic          nr_key_r;         // not-ready key latched
  logic          pwait_r;          // print cycle outstanding
  logic [TW-1:0] pcnt_r;           // watchdog count

  // per-cycle decisions
  logic [7:0] st_set;              // status bits to raise
  logic [7:0] sn_set;              // sense bits to raise
  logic [7:0] csw_stat;            // status to store
  logic       csw_load;            // store a csw this cycle
  logic       st_clr;              // clear status at attachment
  logic       sn_clr;              // clear sense
  logic       ce_acc_set;          // remember ce was stored
  logic       il_set;              // incorrect length detected
  logic       zero_set;            // write zero or end key seen
  logic       pstart;              // printer started a character
  logic       ptimeout;            // printer watchdog expired
  logic       stop_now;            // end sense transfer
  logic       ready_nxt;           // unit ready next cycle
  logic       free;                // nothing in progress or pending
  logic       cmd_rw;              // read or write family
  logic       cmd_def;             // command byte defined

  assign ptimeout = pwait_r && (pcnt_r == TW'(TIMEOUT_CYC - 1));
  assign free     = (op_r == OP_IDLE) && (status_r == '0) && !ce_acc_r;
  assign cmd_rw   = (CMD_BYTE == CMD_READ) || (CMD_BYTE == CMD_WRITE) ||
                    (CMD_BYTE == CMD_WACR);
  assign cmd_def  = cmd_rw || (CMD_BYTE == CMD_SENSE) ||
                    (CMD_BYTE == CMD_NOOP) || (CMD_BYTE == CMD_ALARM);

  ////////////////////////////////////////////////////////////////////////////
  // ready tracking
  always_comb begin
    ready_nxt = !keys_s.cover_open && !keys_s.no_forms &&
                !(nr_key_r || rise.nready_key) ;
    if (rise.ready_key) begin
      ready_nxt = !keys_s.cover_open && !keys_s.no_forms;
    end
  end

  // not-ready key latch, released by the ready key
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      nr_key_r <= 1'b0;
      ready_r  <= 1'b0;
    end else begin
      if (rise.ready_key)       nr_key_r <= 1'b0;
      else if (rise.nready_key) nr_key_r <= 1'b1;
      ready_r <= ready_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel instructions and operation progress
  always_comb begin
    st_set     = '0;
    sn_set     = '0;
    csw_stat   = '0;
    csw_load   = 1'b0;
    st_clr     = 1'b0;
    sn_clr     = 1'b0;
    ce_acc_set = 1'b0;
    il_set     = 1'b0;
    zero_set   = 1'b0;
    pstart     = 1'b0;
    stop_now   = 1'b0;
    op_nxt     = op_r;

    // start i/o: priority follows the busy cases
    if (SIO) begin
      csw_load = 1'b1;
      if (ce_acc_r && status_r[ST_DE]) begin
        csw_stat[ST_BUSY] = 1'b1;
        csw_stat[ST_DE]   = 1'b1;
        st_clr            = 1'b1;
      end else if (ce_acc_r) begin
        csw_stat[ST_BUSY] = 1'b1;
      end else if (status_r[ST_ATTN]) begin
        csw_stat[ST_BUSY] = 1'b1;
        csw_stat[ST_ATTN] = 1'b1;
        st_clr            = 1'b1;
      end else if (status_r[ST_DE]) begin
        csw_stat[ST_BUSY] = 1'b1;
        csw_stat[ST_DE]   = 1'b1;
        st_clr            = 1'b1;
      end else if (op_r != OP_IDLE || status_r != '0) begin
        csw_stat[ST_BUSY] = 1'b1;  // other work still owns the unit
      end else if (!cmd_def) begin
        sn_clr          = 1'b1;
        sn_set[SN_REJ]  = 1'b1;
        csw_stat[ST_UC] = 1'b1;
      end else if (CMD_BYTE == CMD_NOOP || CMD_BYTE == CMD_ALARM) begin
        st_set[ST_CE] = 1'b1;
        st_set[ST_DE] = 1'b1;
      end else if (cmd_rw && !ready_r) begin
        sn_clr          = 1'b1;
        sn_set[SN_INTV] = 1'b1;
        csw_stat[ST_UC] = 1'b1;
      end else if (CMD_BYTE == CMD_SENSE) begin
        op_nxt = OP_SENSE;
      end else begin
        sn_clr = 1'b1;  // fresh operation, fresh sense
        if (CMD_BYTE == CMD_READ)       op_nxt = OP_READ;
        else if (CMD_BYTE == CMD_WRITE) op_nxt = OP_WRITE;
        else                            op_nxt = OP_WACR;
      end
    // test i/o stores and clears, unless ce already taken
    end else if (TIO) begin
      csw_load = 1'b1;
      if (ce_acc_r && !status_r[ST_DE]) begin
        csw_stat[ST_BUSY] = 1'b1;
      end else begin
        csw_stat = status_r;
        st_clr   = 1'b1;
        if (!ready_r) begin
          csw_stat[ST_UC] = 1'b1;
          sn_set[SN_INTV] = 1'b1;
        end
        ce_acc_set = status_r[ST_CE] && !status_r[ST_DE] && (op_r != OP_IDLE);
      end
    // interruption stores pending status
    end else if (INT_ACK && status_r != '0) begin
      csw_load   = 1'b1;
      csw_stat   = status_r;
      st_clr     = 1'b1;
      ce_acc_set = status_r[ST_CE] && !status_r[ST_DE] && (op_r != OP_IDLE);
    end

    // progress of the running operation
    case (op_r)
      OP_READ: begin
        if (rise.kb_strobe) begin
          pstart = 1'b1;
          if (kb_even) sn_set[SN_EQP] = 1'b1;
        end
        if (rise.cancel_key) begin
          st_set[ST_CE] = 1'b1;
          st_set[ST_UX] = 1'b1;
          il_set        = !COUNT_ZERO && !LENGTH_SUPPRESS_FLAG;
          op_nxt        = OP_CRWAIT;
        end else if (rise.end_key) begin
          st_set[ST_CE] = 1'b1;
          il_set        = !COUNT_ZERO && !LENGTH_SUPPRESS_FLAG;
          op_nxt        = OP_CRWAIT;
        end else if (COUNT_ZERO && rise.kb_strobe) begin
          st_set[ST_CE] = 1'b1;
          il_set        = !LENGTH_SUPPRESS_FLAG;
          op_nxt        = OP_CRWAIT;
        end
        if (op_nxt == OP_CRWAIT && !ready_r) begin
          sn_set[SN_INTV] = 1'b1;
        end
      end
      OP_WRITE, OP_WACR: begin
        if (DATA_PAR_ERR) sn_set[SN_BUS] = 1'b1;
        if (rise.end_key) zero_set = 1'b1;
        if (SHARE) begin
          if (zero_seen_r) begin
            st_set[ST_CE] = 1'b1;
            if (!ready_r) sn_set[SN_INTV] = 1'b1;
            if (op_r == OP_WRITE) begin
              st_set[ST_DE] = 1'b1;
              op_nxt        = OP_IDLE;
            end else begin
              op_nxt = OP_CRWAIT;
            end
          end else if (COUNT_ZERO) begin
            zero_set = 1'b1;
          end else begin
            pstart = 1'b1;
          end
        end
      end
      OP_SENSE: begin
        if (SENSE_SENT) begin
          st_set[ST_CE] = 1'b1;
          st_set[ST_DE] = 1'b1;
          stop_now      = 1'b1;
          sn_clr        = 1'b1;
          op_nxt        = OP_IDLE;
        end
      end
      OP_CRWAIT: begin
        if (rise.cr_begin) begin
          st_set[ST_DE] = 1'b1;
          op_nxt        = OP_IDLE;
        end
      end
      default: ;
    endcase

    // printer never answered
    if (ptimeout && (op_r == OP_READ || op_r == OP_WRITE || op_r == OP_WACR)) begin
      sn_set[SN_EQP] = 1'b1;
      st_set[ST_CE]  = 1'b1;
      st_set[ST_DE]  = 1'b1;
      op_nxt         = OP_IDLE;
    end

    if (rise.sync_chk) sn_set[SN_EQP] = 1'b1;
    if (rise.ready_key && !ready_r && ready_nxt) begin
      st_set[ST_DE] = 1'b1;
    end
    if (rise.request && free && !SIO) begin
      st_set[ST_ATTN] = 1'b1;
    end else if (attn_pend_r && free && !SIO && !TIO) begin
      st_set[ST_ATTN] = 1'b1;
    end

    sn_set = sn_set & SENSE_USED;
    // only a stored word that already shows unit check covers new sense
    if (sn_set != '0 && !(csw_load && csw_stat[ST_UC])) st_set[ST_UC] = 1'b1;
    if (HIO) op_nxt = OP_IDLE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // operation register
  always_ff @(posedge CLOCK) begin
    if (RESET) op_r <= OP_IDLE;
    else       op_r <= op_nxt;
  end

  // status byte: sets win over clears, two bits masked out
  always_ff @(posedge CLOCK) begin
    if (RESET) status_r <= STATUS_RST;
    else       status_r <= ((st_clr ? '0 : status_r) | st_set) & ~STATUS_NEVER;
  end

  // sense byte: new errors win over the clear
  always_ff @(posedge CLOCK) begin
    if (RESET) sense_r <= SENSE_RST;
    else       sense_r <= ((sn_clr ? '0 : sense_r) | sn_set) & SENSE_USED;
  end

  // ce stored, device end still owed; dropped once de is stored
  always_ff @(posedge CLOCK) begin
    if (RESET)                           ce_acc_r <= 1'b0;
    else if (ce_acc_set)                 ce_acc_r <= 1'b1;
    else if (st_clr && status_r[ST_DE])  ce_acc_r <= 1'b0;
    else if (HIO && !status_r[ST_DE])    ce_acc_r <= 1'b0;
  end

  // write end detection, ce follows on the next share cycle
  always_ff @(posedge CLOCK) begin
    if (RESET)                 zero_seen_r <= 1'b0;
    else if (zero_set)         zero_seen_r <= 1'b1;
    else if (op_nxt != op_r)   zero_seen_r <= 1'b0;
  end

  // incorrect length waits for the next store
  always_ff @(posedge CLOCK) begin
    if (RESET)          il_r <= 1'b0;
    else if (il_set)    il_r <= 1'b1;
    else if (st_clr)    il_r <= 1'b0;
  end

  // deferred attention; a new press wins over the take-up
  always_ff @(posedge CLOCK) begin
    if (RESET)                          attn_pend_r <= 1'b0;
    else if (rise.request && !free)     attn_pend_r <= 1'b1;
    else if (st_set[ST_ATTN])           attn_pend_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // printer watchdog; restarts on each character, stops on completion
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      pwait_r <= 1'b0;
      pcnt_r  <= '0;
    end else if (pstart) begin
      pwait_r <= 1'b1;
      pcnt_r  <= '0;
    end else if (rise.print_done || ptimeout || op_r == OP_IDLE) begin
      pwait_r <= 1'b0;
      pcnt_r  <= '0;
    end else if (pwait_r) begin
      pcnt_r  <= pcnt_r + TW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered answers to the channel
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      CHANNEL_STATUS_WORD       <= '0;
      XFER_STOP <= 1'b0;
    end else begin
      CHANNEL_STATUS_WORD.valid  <= csw_load;
      CHANNEL_STATUS_WORD.status <= csw_load ? (csw_stat & ~STATUS_NEVER) : CHANNEL_STATUS_WORD.status;
      CHANNEL_STATUS_WORD.il     <= csw_load ? (il_r && st_clr) : CHANNEL_STATUS_WORD.il;
      XFER_STOP  <= stop_now;
    end
  end

  // visible state
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      UNIT_STATUS <= STATUS_RST;
      SENSE_BYTE  <= SENSE_RST;
      UNIT_READY  <= 1'b0;
    end else begin
      UNIT_STATUS <= status_r;
      SENSE_BYTE  <= sense_r;
      UNIT_READY  <= ready_r;
    end
  end

endmodule : console_status_sense

// ===== rtl/pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // asynchronous in, synchronous out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;  // first stage, read only by q

  ////////////////////////////////////////////////////////////////////////////
  // plain two-stage synchroniser
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : pin_sync

// ===== shared/console_pkg.sv
package console_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // unit status bit positions (bit 0 of the byte is the msb)
  localparam int ST_ATTN = 7;  // attention
  localparam int ST_MOD  = 6;  // status modifier, never used
  localparam int ST_CUE  = 5;  // control-unit end, never used
  localparam int ST_BUSY = 4;  // busy
  localparam int ST_CE   = 3;  // channel end
  localparam int ST_DE   = 2;  // device end
  localparam int ST_UC   = 1;  // unit check
  localparam int ST_UX   = 0;  // unit exception

  // sense bit positions (bit 0 of the byte is the msb)
  localparam int SN_REJ  = 7;  // command reject
  localparam int SN_INTV = 6;  // intervention required
  localparam int SN_BUS  = 5;  // bus out check
  localparam int SN_EQP  = 4;  // equipment check

  // status bits the attachment never raises, sense bits it may raise
  localparam logic [7:0] STATUS_NEVER = 8'h60;  // modifier and cu end
  localparam logic [7:0] SENSE_USED   = 8'hF0;  // sense bits 0..3 only
  localparam logic [7:0] STATUS_RST   = 8'h00;
  localparam logic [7:0] SENSE_RST    = 8'h00;

  // command bytes; arbitrary plain defaults
  localparam logic [7:0] CMD_WRITE = 8'h01;
  localparam logic [7:0] CMD_WACR  = 8'h09;
  localparam logic [7:0] CMD_READ  = 8'h0A;
  localparam logic [7:0] CMD_SENSE = 8'h04;
  localparam logic [7:0] CMD_NOOP  = 8'h03;
  localparam logic [7:0] CMD_ALARM = 8'h0B;

  // printer watchdog
  localparam int PRINT_TIMEOUT_MS = 2000;
  localparam int CLK_PERIOD_NS    = 50;
  localparam int PRINT_TIMEOUT_CYC = PRINT_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;

  // operation in progress
  typedef enum logic [2:0] {
    OP_IDLE   = 3'b000,
    OP_READ   = 3'b001,
    OP_WRITE  = 3'b010,
    OP_WACR   = 3'b011,
    OP_SENSE  = 3'b100,
    OP_CRWAIT = 3'b101
  } op_t;

  // stored channel status word answer
  typedef struct packed {
    logic       valid;   // one-cycle pulse
    logic [7:0] status;  // unit status as stored
    logic       il;      // incorrect length
  } csw_t;

  // typewriter pins
  typedef struct packed {
    logic       request;     // request key
    logic       ready_key;   // ready key
    logic       nready_key;  // not-ready key
    logic       end_key;     // end key
    logic       cancel_key;  // cancel key
    logic       cover_open;  // cover switch
    logic       no_forms;    // forms switch
    logic       kb_strobe;   // keyboard character present
    logic       cr_begin;    // carrier return motion started
    logic       print_done;  // print cycle completed
    logic       sync_chk;    // print-sync check
    logic [8:0] kb_char;     // character with parity bit
  } keys_t;

endpackage : console_pkg

// ===== test/channel_model.sv
`timescale 1ns/10ps
module channel_model
  import console_pkg::*;
(
  // clock and stored status word
  input  wire logic              clock,
  input  wire console_pkg::csw_t channel_status_word,
  // sio tio hio int_ack share sense_sent par_err
  output logic [6:0]             strobe,
  output logic [7:0]             cmd_byte
);
  // quiet lines from time zero
  initial begin
    strobe = 7'h00;
    cmd_byte = 8'h00;
  end
  // raise after a falling edge, hold over one rising edge, then poll
  // a few cycles since the stored word stands for one cycle only
  task automatic issue(input logic [6:0] s, input logic [7:0] c, output logic got,
                       output csw_t w);
    got = 1'b0;
    w = '0;
    @(negedge clock);
    strobe = s;
    cmd_byte = c;
    @(negedge clock);
    strobe = 7'h00;
    cmd_byte = ~c;  // released lines never keep the old command
    for (int i = 0; i < 3; i++) begin
      if (channel_status_word.valid === 1'b1 && !got) begin
        got = 1'b1;
        w = channel_status_word;
      end
      @(negedge clock);
    end
  endtask : issue
endmodule : channel_model

// ===== test/console_status_sense_properties.sv
`timescale 1ns/10ps
module console_status_sense_properties
  import console_pkg::*;
(
  // clock and reset
  input wire logic              CLOCK,
  input wire logic              RESET,
  // channel strobes
  input wire logic              SIO,
  input wire logic              TIO,
  input wire logic              HIO,
  input wire logic              INT_ACK,
  input wire logic [7:0]        CMD_BYTE,
  input wire logic              SENSE_SENT,
  // answers
  input wire console_pkg::csw_t CHANNEL_STATUS_WORD,
  input wire logic [7:0]        UNIT_STATUS,
  input wire logic [7:0]        SENSE_BYTE,
  input wire logic              XFER_STOP
);
  // one clock domain, quiet while in reset
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RESET);
  logic imm;    // immediate command offered
  logic ce_de;  // normal ending pair shown
  assign imm = SIO && (CMD_BYTE == CMD_NOOP || CMD_BYTE == CMD_ALARM);
  assign ce_de = UNIT_STATUS[ST_CE] && UNIT_STATUS[ST_DE];
  ////////////////////////////////////////
  a_never_mod_cue: assert property (((UNIT_STATUS | CHANNEL_STATUS_WORD.status) & STATUS_NEVER) == 8'h00)
    else $error("modifier or cu end raised");
  a_sense_low_zero: assert property ((SENSE_BYTE & ~SENSE_USED) == 8'h00)
    else $error("sense low nibble set");
  a_check_with_sense: assert property (
    $rose(|SENSE_BYTE) |-> ##[0:2] (UNIT_STATUS[ST_UC] || CHANNEL_STATUS_WORD.status[ST_UC]))
    else $error("sense set without unit check");
  a_io_answered: assert property ((SIO || TIO) |=> CHANNEL_STATUS_WORD.valid)
    else $error("no stored status word");
  a_quiet_no_store: assert property (!(SIO || TIO || INT_ACK) |=> !CHANNEL_STATUS_WORD.valid)
    else $error("status stored unasked");
  // an accepted immediate command ends at once
  a_immediate_ends: assert property (
    imm ##1 (CHANNEL_STATUS_WORD.valid && CHANNEL_STATUS_WORD.status == 8'h00) |-> ##[0:2] ce_de)
    else $error("immediate command not ended");
  a_sense_one_byte: assert property (SENSE_SENT |=> XFER_STOP ##1 !XFER_STOP)
    else $error("sense transfer not stopped");
  a_sense_ends_all: assert property (SENSE_SENT |-> ##[1:3] ce_de)
    else $error("sense byte without ending");
  a_halt_keeps_de: assert property (
    HIO && UNIT_STATUS[ST_DE] && !(SIO || TIO || INT_ACK) |=> UNIT_STATUS[ST_DE] [*2])
    else $error("halt dropped device end");
  a_test_clears_de: assert property (TIO && !SIO |-> ##3 !UNIT_STATUS[ST_DE])
    else $error("test left device end");
  c_busy_answer: cover property (CHANNEL_STATUS_WORD.valid && CHANNEL_STATUS_WORD.status[ST_BUSY]);
  c_sense_stop: cover property (SENSE_SENT ##1 XFER_STOP);
  c_length_flag: cover property (CHANNEL_STATUS_WORD.valid && CHANNEL_STATUS_WORD.il);
endmodule : console_status_sense_properties
bind console_status_sense console_status_sense_properties console_status_sense_properties_i (
  .CLOCK(CLOCK), .RESET(RESET), .SIO(SIO), .TIO(TIO), .HIO(HIO), .INT_ACK(INT_ACK),
  .CMD_BYTE(CMD_BYTE), .SENSE_SENT(SENSE_SENT), .CHANNEL_STATUS_WORD(CHANNEL_STATUS_WORD), .UNIT_STATUS(UNIT_STATUS),
  .SENSE_BYTE(SENSE_BYTE), .XFER_STOP(XFER_STOP));

// ===== test/console_status_sense_tb_top.sv
`timescale 1ns/10ps
module console_status_sense_tb_top;
  import console_pkg::*;
  localparam int TO = 100;  // short watchdog keeps the run brief
  // strobe masks, in channel model order
  localparam logic [6:0] K_SIO = 7'h40, K_TIO = 7'h20, K_HIO = 7'h10, K_ACK = 7'h08;
  localparam logic [6:0] K_SHR = 7'h04, K_SNS = 7'h02, K_PAR = 7'h01;
  // expected status bits
  localparam logic [7:0] S_ATTN = 8'(1 << ST_ATTN), S_BUSY = 8'(1 << ST_BUSY);
  localparam logic [7:0] S_DE = 8'(1 << ST_DE), S_UC = 8'(1 << ST_UC);
  localparam logic [7:0] S_UX = 8'(1 << ST_UX), S_CD = 8'(1 << ST_CE) | S_DE;
  // key bit positions inside keys_t
  localparam int K_REQ = 19, K_RDY = 18, K_NRDY = 17, K_CAN = 15, K_STB = 12, K_CR = 11;
  localparam int K_SYN = 9;
  logic       clock, reset, count_zero, length_suppress_flag, unit_ready, xfer_stop;
  logic [6:0] strobe;    // channel strobes
  logic [7:0] cmd_byte, unit_status, sense_byte;
  keys_t      keys;      // typewriter pins
  csw_t       channel_status_word;       // stored status word
  logic       last_il;   // length flag of last store
  int         errors, n_compared;
  int         n_stop = 0;  // transfer stop pulses seen
  ////////////////////////////////////////
  console_status_sense #(.TIMEOUT_CYC(TO)) console_status_sense_i (
    .CLOCK(clock), .RESET(reset), .SIO(strobe[6]), .TIO(strobe[5]), .HIO(strobe[4]),
    .INT_ACK(strobe[3]), .CMD_BYTE(cmd_byte), .SHARE(strobe[2]), .COUNT_ZERO(count_zero),
    .LENGTH_SUPPRESS_FLAG(length_suppress_flag), .DATA_PAR_ERR(strobe[0]), .SENSE_SENT(strobe[1]), .KEYS(keys), .CHANNEL_STATUS_WORD(channel_status_word),
    .UNIT_STATUS(unit_status), .SENSE_BYTE(sense_byte), .UNIT_READY(unit_ready),
    .XFER_STOP(xfer_stop));
  channel_model channel_model_i (.clock(clock), .channel_status_word(channel_status_word), .strobe(strobe), .cmd_byte(cmd_byte));
  // stop pulse stands one cycle, so count it mid-cycle
  always @(negedge clock) if (xfer_stop === 1'b1) n_stop++;
  // free running clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t %s seen %h want %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  // instruction that must store a status word
  task automatic io(input logic [6:0] s, input logic [7:0] c, input logic [7:0] exp);
    logic got;
    csw_t w;
    channel_model_i.issue(s, c, got, w);
    check({7'h00, got}, 8'h01, "csw stored");
    if (got !== 1'b1) stop_test();
    check(w.status, exp, "csw status");
    last_il = w.il;
  endtask : io
  // strobe with no answer looked for
  task automatic pulse(input logic [6:0] s);
    logic got;
    csw_t w;
    channel_model_i.issue(s, 8'h00, got, w);
  endtask : pulse
  // key held long enough to pass the pin synchronisers
  task automatic press(input int b);
    keys[b] = 1'b1;
    repeat (3) @(negedge clock);
    keys[b] = 1'b0;
    repeat (6) @(negedge clock);
  endtask : press
  task automatic st(input logic [7:0] exp);
    repeat (3) @(negedge clock);
    check(unit_status, exp, "unit status");
  endtask : st
  ////////////////////////////////////////
  initial begin
    errors = 0;
    n_compared = 0;
    keys = '0;  // cover shut, forms in
    count_zero = 1'b0;
    length_suppress_flag = 1'b0;
    reset = 1'b1;
    repeat (4) @(negedge clock);
    reset = 1'b0;
    check(unit_status, STATUS_RST, "status reset");
    check(sense_byte, SENSE_RST, "sense reset");
    for (int i = 0; i < 50 && unit_ready !== 1'b1; i++) @(negedge clock);
    check({7'h00, unit_ready}, 8'h01, "ready");
    if (unit_ready !== 1'b1) stop_test();
    // both immediate commands end at once
    for (int i = 0; i < 2; i++) begin
      io(K_SIO, i ? CMD_ALARM : CMD_NOOP, 8'h00);
      st(S_CD);
      io(K_ACK, 8'h00, S_CD);
    end
    io(K_TIO, 8'h00, 8'h00);
    $display("test immediate done");
    press(K_REQ);
    st(S_ATTN);
    io(K_SIO, CMD_NOOP, S_BUSY | S_ATTN);
    st(8'h00);
    $display("test attention done");
    // even parity char, then cancel: read must keep going
    io(K_SIO, CMD_READ, 8'h00);
    keys.kb_char = 9'h003;
    press(K_STB);
    check(sense_byte, 8'(1 << SN_EQP), "parity sense");
    press(K_CAN);
    st(S_CD ^ S_DE | S_UX | S_UC);
    io(K_ACK, 8'h00, S_CD ^ S_DE | S_UX | S_UC);
    check({7'h00, last_il}, 8'h01, "length flag");
    io(K_SIO, CMD_NOOP, S_BUSY);
    st(8'h00);
    press(K_CR);
    st(S_DE);
    io(K_SIO, CMD_NOOP, S_BUSY | S_DE);
    st(8'h00);
    $display("test read done");
    // channel end one share after the empty count
    length_suppress_flag = 1'b1;
    io(K_SIO, CMD_WRITE, 8'h00);
    check(sense_byte, 8'h00, "sense cleared");
    count_zero = 1'b1;
    pulse(K_SHR);
    st(8'h00);
    pulse(K_SHR);
    st(S_CD);
    io(K_ACK, 8'h00, S_CD);
    count_zero = 1'b0;
    $display("test write done");
    io(K_SIO, 8'hFF, S_UC);
    check(sense_byte, 8'(1 << SN_REJ), "reject sense");
    io(K_SIO, CMD_SENSE, 8'h00);
    pulse(K_SNS);
    check(8'(n_stop), 8'h01, "one stop pulse");
    st(S_CD);
    check(sense_byte, 8'h00, "sense sent");
    io(K_ACK, 8'h00, S_CD);
    $display("test sense done");
    press(K_SYN);
    check(sense_byte, 8'(1 << SN_EQP), "sync check sense");
    st(S_UC);
    io(K_TIO, 8'h00, S_UC);
    press(K_NRDY);
    check({7'h00, unit_ready}, 8'h00, "not ready");
    io(K_SIO, CMD_WRITE, S_UC);
    check(sense_byte, 8'(1 << SN_INTV), "intervention");
    press(K_RDY);
    st(S_DE);
    pulse(K_HIO);
    st(S_DE);
    io(K_SIO, CMD_NOOP, S_BUSY | S_DE);
    press(K_RDY);
    st(8'h00);
    $display("test ready done");
    // last: watchdog ends the write, leaving status behind
    io(K_SIO, CMD_WRITE, 8'h00);
    pulse(K_PAR);
    check(sense_byte, 8'(1 << SN_BUS), "bus out");
    pulse(K_SHR);
    repeat (TO + 20) @(negedge clock);
    check(sense_byte, 8'(1 << SN_BUS) | 8'(1 << SN_EQP), "watchdog sense");
    check({7'h00, unit_status[ST_UC]}, 8'h01, "watchdog check");
    $display("test watchdog done");
    stop_test();
  end
endmodule : console_status_sense_tb_top
